// >>> design/tetc_chan.sv
// One count-up counter channel with event, timer and pulse-width modes.
// Assumes edge pulses and prescaled ticks already in the core clock domain.
`timescale 1ns/1ps
module tetc_chan
  import tetc_pkg::*;
#(
  parameter int W = W12
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire tetc_mode_t   mode,
  input  wire logic         count_enable,
  input  wire logic         active_edge_select,
  input  wire logic         tick,
  input  wire logic         pin_rise,
  input  wire logic         pin_fall,
  input  wire logic         load,
  input  wire logic [W-1:0] preload,
  output logic      [W-1:0] count_q,
  output logic              ovf,
  output logic              done
);
  tetc_meas_t meas_q;
  logic       start_edge;
  logic       stop_edge;
  logic       evt_edge;
  logic       inc;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  always_comb begin
    start_edge = active_edge_select ? pin_rise : pin_fall;
    stop_edge  = active_edge_select ? pin_fall : pin_rise;
    evt_edge   = active_edge_select ? pin_fall : pin_rise;
    case (mode)
      TETC_M_EVENT: inc = count_enable && evt_edge;
      TETC_M_TIMER: inc = count_enable && tick;
      TETC_M_PWM: inc = count_enable && meas_q == TETC_MEAS &&
                        tick && !stop_edge;
      default: inc = 1'b0;
    endcase
    ovf  = inc && count_q == {W{1'b1}};
    done = mode == TETC_M_PWM && count_enable &&
           meas_q == TETC_MEAS && stop_edge;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meas_q <= TETC_IDLE;
    end else begin
      case (meas_q)
        TETC_IDLE: begin
          if (mode == TETC_M_PWM && count_enable && start_edge) begin
            meas_q <= TETC_MEAS;
          end
        end
        TETC_MEAS: begin
          if (!count_enable || mode != TETC_M_PWM || stop_edge) begin
            meas_q <= TETC_IDLE;
          end
        end
        default: meas_q <= TETC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (load && !count_enable) begin
      count_q <= preload;
    end else if (ovf) begin
      count_q <= preload;
    end else if (inc) begin
      count_q <= count_q + 1'b1;
    end
  end

  sequence pwm_start_s;
    mode == TETC_M_PWM && count_enable && meas_q == TETC_IDLE &&
    start_edge;
  endsequence

  sequence pwm_end_s;
    mode == TETC_M_PWM && meas_q == TETC_MEAS && stop_edge &&
    count_enable;
  endsequence

  wrap_reload_a: assert property (
    ovf && !load |=> count_q == $past(preload))
    else $error("Overflow did not reload from preload.");

  pwm_start_a: assert property (pwm_start_s |=> meas_q == TETC_MEAS)
    else $error("Pulse measurement did not start on active edge.");

  pwm_stop_a: assert property (
    pwm_end_s |-> done ##1 meas_q == TETC_IDLE)
    else $error("Pulse measurement did not stop on return edge.");

  event_no_tick_a: assert property (
    mode == TETC_M_EVENT && !pin_rise && !pin_fall && !load
    |=> $stable(count_q))
    else $error("Event counter moved without a pin edge.");

  hold_off_a: assert property (
    !count_enable && !load |=> $stable(count_q))
    else $error("Counter moved while counting disabled.");
endmodule

// >>> design/tetc_pkg.sv
// Constants, register map and types of the triple timer/event counter.
// Assumes one core clock; all other clocks arrive as sampled levels.
package tetc_pkg;
  localparam int NCH = 3;
  localparam int W0  = 8;
  localparam int W12 = 16;
  localparam int AW  = 8;
  localparam int DW  = 8;

  localparam logic [7:0] A_C0_VAL  = 8'h00;
  localparam logic [7:0] A_C0_CTRL = 8'h01;
  localparam logic [7:0] A_C1_LO   = 8'h02;
  localparam logic [7:0] A_C1_HI   = 8'h03;
  localparam logic [7:0] A_C1_CTRL = 8'h04;
  localparam logic [7:0] A_C2_LO   = 8'h05;
  localparam logic [7:0] A_C2_HI   = 8'h06;
  localparam logic [7:0] A_C2_CTRL = 8'h07;
  localparam logic [7:0] A_SYSCTL  = 8'h08;
  localparam logic [7:0] A_INTCTL  = 8'h09;

  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_SRC     = 5;
  localparam int B_EN      = 4;
  localparam int B_EDGE    = 3;
  localparam int B_PSC_HI  = 2;
  localparam int B_LFS     = 0;
  localparam int B_AUX_LO  = 1;
  localparam int B_AUX_HI  = 2;
  localparam int B_FLAG0   = 4;

  localparam logic [1:0] AUX_LF   = 2'h0;
  localparam logic [1:0] AUX_REF  = 2'h1;
  localparam logic [1:0] AUX_SEN  = 2'h2;
  localparam logic [1:0] AUX_TMCK = 2'h3;

  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam int         PSC_W     = 7;
  localparam logic [6:0] PSC_ALL   = 7'h7f;
  localparam logic [2:0] PSC_MAX   = 3'h7;

  localparam int NSYNC  = 8;
  localparam int S_INTERNAL_LOW_SPEED_RC = 0;
  localparam int S_LXT  = 1;
  localparam int S_REF  = 2;
  localparam int S_SEN  = 3;
  localparam int S_TMCK = 4;
  localparam int S_PIN0 = 5;

  typedef enum logic [1:0] {
    TETC_M_NONE  = 2'b00,
    TETC_M_EVENT = 2'b01,
    TETC_M_TIMER = 2'b10,
    TETC_M_PWM   = 2'b11
  } tetc_mode_t;

  typedef enum logic {
    TETC_IDLE = 1'b0,
    TETC_MEAS = 1'b1
  } tetc_meas_t;
endpackage

// >>> design/tetc_top.sv
// Top of the triple timer/event counter with its register port.
// Assumes a byte register port on core_clk; pins and slow clocks are async.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tetc_top
  import tetc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata_q,
  input  wire logic [NCH-1:0] event_pin,
  input  wire logic          internal_low_speed_rc,
  input  wire logic          external_low_speed_crystal,
  input  wire logic          touch_ref_clock,
  input  wire logic          touch_sense_clock,
  input  wire logic          touch_timer_clock,
  output logic      [NCH-1:0] overflow_irq_q
);
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;

  logic [DW-1:0]    ctrl_q    [NCH];
  logic [W12-1:0]   preload_q [NCH];
  logic [W12-1:0]   count_w   [NCH];
  logic [NCH-1:0]   load_q;
  logic [DW-1:0]    lowbuf1_q;
  logic [DW-1:0]    lowbuf2_q;
  logic             lfs_q;
  logic [1:0]       aux_sel_q;
  logic [NCH-1:0]   inten_q;
  logic [NCH-1:0]   flag_q;
  logic [1:0]       div_q;

  logic             div4;
  logic             lf_fall;
  logic             aux_fall;
  logic [NCH-1:0]   src;
  logic [NCH-1:0]   tick;
  logic [NCH-1:0]   ovf;
  logic [NCH-1:0]   done;
  logic [NCH-1:0]   ctrl_wr;
  logic             intc_wr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  assign raw = {event_pin, touch_timer_clock, touch_sense_clock,
                touch_ref_clock, external_low_speed_crystal,
                internal_low_speed_rc};

  // Each async level passes two flops; a third flop feeds edge detection.
  genvar b;
  generate
    for (b = 0; b < NSYNC; b++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          s1_q[b] <= 1'b0;
          s2_q[b] <= 1'b0;
          s3_q[b] <= 1'b0;
        end else begin
          s1_q[b] <= raw[b];
          s2_q[b] <= s1_q[b];
          s3_q[b] <= s2_q[b];
        end
      end
      assign rise[b] = s2_q[b] && !s3_q[b];
      assign fall[b] = !s2_q[b] && s3_q[b];
    end
  endgenerate

  // System clock divided by four as a one-cycle enable.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign div4 = div_q == DIV4_LAST;

  // Slow clocks advance the count on their high-to-low transition.
  always_comb begin
    lf_fall = lfs_q ? fall[S_LXT] : fall[S_INTERNAL_LOW_SPEED_RC];
    case (aux_sel_q)
      AUX_LF: aux_fall = lf_fall;
      AUX_REF: aux_fall = fall[S_REF];
      AUX_SEN: aux_fall = fall[S_SEN];
      default: aux_fall = fall[S_TMCK];
    endcase
    src[0] = ctrl_q[0][B_SRC] ? lf_fall : 1'b1;
    src[1] = ctrl_q[1][B_SRC] ? lf_fall : div4;
    src[2] = ctrl_q[2][B_SRC] ? aux_fall : div4;
  end

  assign intc_wr = reg_wr && reg_addr == A_INTCTL;
  assign ctrl_wr[0] = reg_wr && reg_addr == A_C0_CTRL;
  assign ctrl_wr[1] = reg_wr && reg_addr == A_C1_CTRL;
  assign ctrl_wr[2] = reg_wr && reg_addr == A_C2_CTRL;

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      localparam int CW = (i == 0) ? W0 : W12;
      logic [PSC_W-1:0] psc_q;
      logic [PSC_W-1:0] mask;
      logic [CW-1:0]    cnt;
      logic [2:0]       psc_sel;

      assign psc_sel = ctrl_q[i][B_PSC_HI:0];
      assign mask = PSC_ALL >> (PSC_MAX - psc_sel);
      assign tick[i] = src[i] && (psc_q & mask) == mask;

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          psc_q <= '0;
        end else if (!ctrl_q[i][B_EN]) begin
          psc_q <= '0;
        end else if (src[i]) begin
          psc_q <= psc_q + 1'b1;
        end
      end

      // A hardware clear of the enable loses to a software write.
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          ctrl_q[i] <= CTRL_RST;
        end else if (ctrl_wr[i]) begin
          ctrl_q[i] <= reg_wdata;
        end else if (done[i]) begin
          ctrl_q[i][B_EN] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          flag_q[i] <= 1'b0;
        end else if (ovf[i]) begin
          flag_q[i] <= 1'b1;
        end else if (intc_wr && !reg_wdata[B_FLAG0 + i]) begin
          flag_q[i] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          overflow_irq_q[i] <= 1'b0;
        end else begin
          overflow_irq_q[i] <= flag_q[i] && inten_q[i];
        end
      end

      tetc_chan #(
        .W(CW)
      ) u_chan (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .mode               (tetc_mode_t'(ctrl_q[i][B_MODE_HI:B_MODE_LO])),
        .count_enable       (ctrl_q[i][B_EN]),
        .active_edge_select (ctrl_q[i][B_EDGE]),
        .tick               (tick[i]),
        .pin_rise           (rise[S_PIN0 + i]),
        .pin_fall           (fall[S_PIN0 + i]),
        .load               (load_q[i]),
        .preload            (preload_q[i][CW-1:0]),
        .count_q            (cnt),
        .ovf                (ovf[i]),
        .done               (done[i])
      );
      assign count_w[i] = W12'(cnt);

      ovf_sets_flag_a: assert property (ovf[i] |=> flag_q[i])
        else $error("Overflow did not set its flag.");

      flag_sticky_a: assert property (
        flag_q[i] && !intc_wr |=> flag_q[i])
        else $error("Flag dropped without a clear.");

      irq_mask_a: assert property (
        !inten_q[i] ##1 !inten_q[i] |-> !overflow_irq_q[i])
        else $error("Masked overflow raised a request.");

      irq_raise_a: assert property (
        flag_q[i] && inten_q[i] |=> overflow_irq_q[i])
        else $error("Enabled flag did not raise a request.");

      pwm_clear_en_a: assert property (
        done[i] && !ctrl_wr[i] |=> !ctrl_q[i][B_EN])
        else $error("Pulse end did not clear the enable bit.");

      psc_bypass_a: assert property (
        ctrl_q[i][B_EN] && psc_sel == 3'h0 && src[i] |-> tick[i])
        else $error("Divide-by-one prescaler dropped a tick.");
    end
  endgenerate

  // Preloads: counter 0 takes a byte, counters 1 and 2 take high plus buffer.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      preload_q[0] <= '0;
      preload_q[1] <= '0;
      preload_q[2] <= '0;
      load_q       <= '0;
    end else begin
      load_q[0] <= reg_wr && reg_addr == A_C0_VAL;
      load_q[1] <= reg_wr && reg_addr == A_C1_HI;
      load_q[2] <= reg_wr && reg_addr == A_C2_HI;
      if (reg_wr && reg_addr == A_C0_VAL) begin
        preload_q[0] <= {8'h00, reg_wdata};
      end
      if (reg_wr && reg_addr == A_C1_HI) begin
        preload_q[1] <= {reg_wdata, lowbuf1_q};
      end
      if (reg_wr && reg_addr == A_C2_HI) begin
        preload_q[2] <= {reg_wdata, lowbuf2_q};
      end
    end
  end

  // Low-byte buffers make 16-bit reads and writes atomic.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lowbuf1_q <= '0;
      lowbuf2_q <= '0;
    end else begin
      if (reg_wr && reg_addr == A_C1_LO) begin
        lowbuf1_q <= reg_wdata;
      end else if (reg_rd && reg_addr == A_C1_HI) begin
        lowbuf1_q <= count_w[1][7:0];
      end
      if (reg_wr && reg_addr == A_C2_LO) begin
        lowbuf2_q <= reg_wdata;
      end else if (reg_rd && reg_addr == A_C2_HI) begin
        lowbuf2_q <= count_w[2][7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lfs_q     <= 1'b0;
      aux_sel_q <= AUX_LF;
    end else if (reg_wr && reg_addr == A_SYSCTL) begin
      lfs_q     <= reg_wdata[B_LFS];
      aux_sel_q <= reg_wdata[B_AUX_HI:B_AUX_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inten_q <= '0;
    end else if (intc_wr) begin
      inten_q <= reg_wdata[NCH-1:0];
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= '0;
    end else if (!reg_rd) begin
      reg_rdata_q <= '0;
    end else if (reg_addr == A_C0_VAL) begin
      reg_rdata_q <= count_w[0][7:0];
    end else if (reg_addr == A_C0_CTRL) begin
      reg_rdata_q <= ctrl_q[0];
    end else if (reg_addr == A_C1_LO) begin
      reg_rdata_q <= lowbuf1_q;
    end else if (reg_addr == A_C1_HI) begin
      reg_rdata_q <= count_w[1][15:8];
    end else if (reg_addr == A_C1_CTRL) begin
      reg_rdata_q <= ctrl_q[1];
    end else if (reg_addr == A_C2_LO) begin
      reg_rdata_q <= lowbuf2_q;
    end else if (reg_addr == A_C2_HI) begin
      reg_rdata_q <= count_w[2][15:8];
    end else if (reg_addr == A_C2_CTRL) begin
      reg_rdata_q <= ctrl_q[2];
    end else if (reg_addr == A_SYSCTL) begin
      reg_rdata_q <= {5'h00, aux_sel_q, lfs_q};
    end else if (reg_addr == A_INTCTL) begin
      reg_rdata_q <= {1'b0, flag_q, 1'b0, inten_q};
    end else begin
      reg_rdata_q <= '0;
    end
  end

  sequence hi_read_s;
    reg_rd && reg_addr == A_C1_HI;
  endsequence

  hi_read_latch_a: assert property (
    hi_read_s |=> lowbuf1_q == $past(count_w[1][7:0]) &&
                  reg_rdata_q == $past(count_w[1][15:8]))
    else $error("High read did not latch the low byte.");

  lo_write_buf_a: assert property (
    reg_wr && reg_addr == A_C1_LO |=> $stable(preload_q[1]))
    else $error("Low write changed the preload.");

  hi_write_load_a: assert property (
    reg_wr && reg_addr == A_C1_HI
    |=> preload_q[1] == {$past(reg_wdata), $past(lowbuf1_q)})
    else $error("High write did not pair with buffered low byte.");

  c0_read_a: assert property (
    reg_rd && reg_addr == A_C0_VAL
    |=> reg_rdata_q == $past(count_w[0][7:0]) ##1 1'b1)
    else $error("Counter 0 read did not return the count.");

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
    else $error("Read data stood without a read strobe.");

  div4_rate_a: assert property (div4 |=> !div4 [*3] ##1 div4)
    else $error("Divide-by-four enable not one in four.");
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the triple timer/event counter.
// Assumes the pin source model and one 100 MHz core clock.
`timescale 1ns/1ps
module tb_top
  import tetc_pkg::*;
;
  localparam logic [7:0] lo_addr [3] = '{A_C0_VAL, A_C1_LO, A_C2_LO};
  localparam logic [7:0] hi_addr [3] = '{A_C0_VAL, A_C1_HI, A_C2_HI};
  localparam logic [7:0] ct_addr [3] = '{A_C0_CTRL, A_C1_CTRL, A_C2_CTRL};
  localparam int         aux_shf [4] = '{4, 3, 6, 2};

  logic           core_clk;
  logic           sys_rst;
  logic [AW-1:0]  reg_addr;
  logic [DW-1:0]  reg_wdata;
  logic           reg_wr;
  logic           reg_rd;
  logic [DW-1:0]  reg_rdata_q;
  logic [NCH-1:0] event_pin;
  logic [NCH-1:0] overflow_irq_q;
  logic [7:0]     slow_q;
  logic [15:0]    v;
  logic [15:0]    w;
  logic [7:0]     b;
  int             fail_count;
  int             total_checks;
  int             cyc;

  tetc_top dut (
    .core_clk                  (core_clk),
    .sys_rst                   (sys_rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata_q               (reg_rdata_q),
    .event_pin                 (event_pin),
    .internal_low_speed_rc     (slow_q[3]),
    .external_low_speed_crystal(slow_q[4]),
    .touch_ref_clock           (slow_q[2]),
    .touch_sense_clock         (slow_q[5]),
    .touch_timer_clock         (slow_q[1]),
    .overflow_irq_q            (overflow_irq_q)
  );

  tetc_pin_src src (
    .core_clk (core_clk),
    .event_pin(event_pin)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Slow clocks of periods 4 to 64 core cycles, unrelated to any access.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      slow_q <= 8'h00;
    end else begin
      slow_q <= slow_q + 8'h01;
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Clock phase against the enable write leaves one count of slack.
  task automatic near(string name, logic [15:0] seen, int exp);
    check(name, (seen + 1 >= exp && seen <= exp + 1) ? 16'(exp) : seen,
          16'(exp));
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Taken at this edge before the port drops the data back to zero.
    @(posedge core_clk);
    d = reg_rdata_q;
  endtask

  task automatic set_pre(int ch, logic [15:0] p);
    wr(lo_addr[ch], p[7:0]);
    if (ch != 0) begin
      wr(hi_addr[ch], p[15:8]);
    end
  endtask

  // The high byte goes first so that the low byte is a matching snapshot.
  task automatic get_cnt(int ch, output logic [15:0] c);
    logic [7:0] x;
    c = 16'h0000;
    if (ch != 0) begin
      rd(hi_addr[ch], x);
      c[15:8] = x;
    end
    rd(lo_addr[ch], x);
    c[7:0] = x;
  endtask

  task automatic run(int ch, logic [7:0] ctl, int t);
    wr(ct_addr[ch], ctl);
    repeat (t - 2) @(posedge core_clk);
    wr(ct_addr[ch], ctl & 8'hef);
  endtask

  initial begin
    fail_count = 0;
    total_checks = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sys_rst = 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int c = 0; c < 3; c++) begin
      rd(ct_addr[c], b);
      check("control reset", 16'(b), 16'(CTRL_RST));
    end
    rd(A_INTCTL, b);
    check("intctl reset", 16'(b), 16'h0000);
    wr(8'h3c, 8'hff);
    rd(8'h3c, b);
    check("unmapped", 16'(b), 16'h0000);
    wr(A_SYSCTL, 8'h07);
    rd(A_SYSCTL, b);
    check("sysctl", 16'(b), 16'h0007);
    wr(A_C0_VAL, 8'h5a);
    rd(A_C0_VAL, b);
    check("c0 value", 16'(b), 16'h005a);
    for (int c = 1; c < 3; c++) begin
      set_pre(c, 16'h1234);
      get_cnt(c, v);
      check("wide value", v, 16'h1234);
      wr(lo_addr[c], 8'h77);
      rd(lo_addr[c], b);
      check("low buffer", 16'(b), 16'h0077);
      get_cnt(c, v);
      check("low alone", v, 16'h1234);
    end
    for (int n = 0; n < 8; n++) begin
      set_pre(0, 16'h0000);
      run(0, 8'h90 | 8'(n), 16 << n);
      get_cnt(0, v);
      near("c0 prescale", v, 16);
    end
    repeat (20) @(posedge core_clk);
    get_cnt(0, w);
    check("stopped", w, v);
    wr(A_C0_CTRL, 8'h10);
    repeat (20) @(posedge core_clk);
    get_cnt(0, v);
    check("no mode", v, w);
    wr(A_C0_CTRL, 8'h00);
    for (int c = 1; c < 3; c++) begin
      set_pre(c, 16'h00f8);
      run(c, 8'h90, 64);
      get_cnt(c, v);
      near("sys div4", v, 16'h0108);
    end
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 2; s++) begin
        wr(A_SYSCTL, 8'(s));
        set_pre(c, 16'h0000);
        run(c, 8'hb0, 512);
        get_cnt(c, v);
        near("low clock", v, 512 >> (4 + s));
      end
    end
    for (int s = 0; s < 4; s++) begin
      wr(A_SYSCTL, 8'(s << 1));
      set_pre(2, 16'h0000);
      run(2, 8'hb0, 512);
      get_cnt(2, v);
      near("aux clock", v, 512 >> aux_shf[s]);
    end
    wr(A_INTCTL, 8'h00);
    set_pre(0, 16'h00f0);
    run(0, 8'h90, 20);
    get_cnt(0, v);
    near("c0 reload", v, 16'h00f4);
    check("masked irq", 16'(overflow_irq_q), 16'h0000);
    rd(A_INTCTL, b);
    check("c0 flag", 16'(b), 16'h0010);
    wr(A_INTCTL, 8'h11);
    repeat (2) @(posedge core_clk);
    check("irq on", 16'(overflow_irq_q), 16'h0001);
    run(0, 8'h90, 40);
    check("irq held", 16'(overflow_irq_q), 16'h0001);
    wr(A_INTCTL, 8'h01);
    repeat (2) @(posedge core_clk);
    check("irq cleared", 16'(overflow_irq_q), 16'h0000);
    set_pre(1, 16'hfff0);
    run(1, 8'h90, 80);
    get_cnt(1, v);
    near("c1 reload", v, 16'hfff4);
    rd(A_INTCTL, b);
    check("c1 flag", 16'(b), 16'h0021);
    check("c1 masked", 16'(overflow_irq_q), 16'h0000);
    wr(A_INTCTL, 8'h00);
    for (int c = 0; c < 3; c++) begin
      for (int e = 0; e < 2; e++) begin
        set_pre(c, 16'h0000);
        wr(ct_addr[c], (e != 0) ? 8'h5f : 8'h57);
        src.pulses(c, 5, 3, 3);
        src.level(c, 1'b1);
        repeat (8) @(posedge core_clk);
        wr(ct_addr[c], 8'h47);
        src.level(c, 1'b0);
        get_cnt(c, v);
        check("event count", v, 16'(6 - e));
      end
    end
    set_pre(1, 16'h0000);
    wr(A_C1_CTRL, 8'hd8);
    repeat (6) @(posedge core_clk);
    get_cnt(1, v);
    check("pulse idle", v, 16'h0000);
    src.pulses(1, 1, 40, 10);
    get_cnt(1, v);
    near("pulse width", v, 10);
    rd(A_C1_CTRL, b);
    check("pulse enable", 16'(b), 16'h00c8);
    src.pulses(1, 1, 40, 10);
    get_cnt(1, w);
    check("single shot", w, v);
    src.level(2, 1'b1);
    set_pre(2, 16'h0000);
    repeat (8) @(posedge core_clk);
    wr(A_C2_CTRL, 8'hd0);
    repeat (6) @(posedge core_clk);
    src.pulses(2, 1, 40, 10);
    get_cnt(2, v);
    near("low pulse", v, 10);
    print_verdict();
  end
endmodule

// >>> verif/tetc_pin_src.sv
// Model of the external event sources on the three counter pins.
// Assumes the core clock steps it; pins change only just after an edge.
`timescale 1ns/1ps
module tetc_pin_src
  import tetc_pkg::*;
(
  input  wire logic           core_clk,
  output logic      [NCH-1:0] event_pin
);
  initial event_pin = '0;

  // Toggling rather than forcing a level lets one task serve both polarities.
  task automatic pulses(int ch, int n, int act, int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      event_pin[ch] <= ~event_pin[ch];
      repeat (act) @(posedge core_clk);
      event_pin[ch] <= ~event_pin[ch];
      repeat (gap - 1) @(posedge core_clk);
    end
  endtask

  task automatic level(int ch, logic v);
    @(posedge core_clk);
    event_pin[ch] <= v;
  endtask
endmodule
